/* File: logic/sram_bus_mem.sv */
// Device end: pipelined burst memory with gated clock and deselect.
`timescale 1ns/1ps
`default_nettype none
module sram_bus_mem (
    input  wire logic  sys_clk_i,
    input  wire logic  reset_i,
    sram_bus_if.dev    bus,
    input  wire logic  burst_order_select_i,
    output logic [sram_bus_pkg::BEAT_W-1:0] beat_index_o,
    output logic       pipe_busy_o
);
    localparam int AW = sram_bus_pkg::ADDR_W;
    localparam int DW = sram_bus_pkg::DATA_W;
    localparam int BW = sram_bus_pkg::BEAT_W;
    localparam int LN = sram_bus_pkg::LANES;
    localparam int LW = sram_bus_pkg::LANE_W;
    localparam int MA = sram_bus_pkg::MEM_AW;

    // Replace the byte lanes whose write strobe is low.
    function automatic logic [DW-1:0] merge_lanes(
        input logic [DW-1:0] old_word,
        input logic [DW-1:0] new_word,
        input logic [LN-1:0] lane_n
    );
        logic [DW-1:0] res;
        res = old_word;
        for (int i = 0; i < LN; i++) begin
            if (!lane_n[i]) begin
                res[i*LW +: LW] = new_word[i*LW +: LW];
            end
        end
        return res;
    endfunction

    logic [DW-1:0] mem_r [sram_bus_pkg::MEM_WORDS];

    logic          burst_act_r;
    logic          burst_write_r;
    logic [AW-1:0] base_r;
    logic [BW-1:0] cnt_r;

    logic          s1_valid_r;
    logic          s1_write_r;
    logic [AW-1:0] s1_addr_r;
    logic [LN-1:0] s1_lane_r;

    logic          s2_valid_r;
    logic          s2_write_r;
    logic [AW-1:0] s2_addr_r;
    logic [LN-1:0] s2_lane_r;

    logic [DW-1:0] q_r;
    logic          out_act_r;
    logic          oe_r;

    logic          ce;
    logic          selected;
    logic          load;
    logic          new_op;
    logic          step;
    logic [BW-1:0] cnt_nxt;
    logic [BW-1:0] low_nxt;
    logic [AW-1:0] beat_addr;

    logic          s1_valid_nxt;
    logic          s1_write_nxt;
    logic [AW-1:0] s1_addr_nxt;

    logic [MA-1:0] rd_idx;
    logic [MA-1:0] wr_idx;
    logic          wr_en;
    logic          fwd;
    logic [DW-1:0] rd_word;
    logic          read_due;
    logic          oe_nxt;
    logic          order_meta_r;
    logic          order_sync_r;

    // A gated clock freezes every pipeline register below except oe_r.
    assign ce       = !bus.clock_gate_n;
    assign selected = !bus.chip_select_a_n && bus.chip_select_b
                      && !bus.chip_select_c_n;
    assign load     = ce && !bus.advance_or_load;
    assign new_op   = load && selected;
    assign step     = ce && bus.advance_or_load && burst_act_r;

    // The two-bit counter rolls over to the first beat by itself.
    assign cnt_nxt  = cnt_r + sram_bus_pkg::BEAT_STEP;
    assign low_nxt  = order_sync_r ? (base_r[BW-1:0] ^ cnt_nxt)
                                   : (base_r[BW-1:0] + cnt_nxt);
    assign beat_addr = {base_r[AW-1:BW], low_nxt};

    // A load wins over a running burst, so no idle clock is needed.
    assign s1_valid_nxt = new_op || (step && !load);
    assign s1_write_nxt = new_op ? !bus.read_write : burst_write_r;
    assign s1_addr_nxt  = new_op ? bus.addr : beat_addr;

    assign rd_idx  = s1_addr_r[MA-1:0];
    assign wr_idx  = s2_addr_r[MA-1:0];
    assign wr_en   = ce && s2_valid_r && s2_write_r;

    // Forwarding covers a read loaded right behind a write to that word.
    assign fwd     = wr_en && (wr_idx == rd_idx);
    assign rd_word = fwd ? merge_lanes(mem_r[rd_idx], bus.bus_dq, s2_lane_r)
                         : mem_r[rd_idx];

    assign read_due = s1_valid_r && !s1_write_r;

    // Output enable acts even while the clock is gated off.
    assign oe_nxt  = (ce ? read_due : out_act_r)
                     && !bus.output_enable_n;

    assign bus.dev_dq    = q_r;
    assign bus.dev_dq_oe = oe_r;

    // The order strap comes from off chip, so it passes two flops first.
    always_ff @(posedge sys_clk_i) begin
        order_meta_r <= burst_order_select_i;
        order_sync_r <= order_meta_r;
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            burst_act_r   <= 1'h0;
            burst_write_r <= 1'h0;
            base_r        <= '0;
            cnt_r         <= sram_bus_pkg::BEAT_FIRST;
        end else if (new_op) begin
            burst_act_r   <= 1'h1;
            burst_write_r <= !bus.read_write;
            base_r        <= bus.addr;
            cnt_r         <= sram_bus_pkg::BEAT_FIRST;
        end else if (load) begin
            burst_act_r   <= 1'h0;
        end else if (step) begin
            cnt_r         <= cnt_nxt;
        end
    end

    // Two enabled clocks from load to the data cycle.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            s1_valid_r <= 1'h0;
            s1_write_r <= 1'h0;
            s1_addr_r  <= '0;
            s1_lane_r  <= sram_bus_pkg::LANES_OFF;
            s2_valid_r <= 1'h0;
            s2_write_r <= 1'h0;
            s2_addr_r  <= '0;
            s2_lane_r  <= sram_bus_pkg::LANES_OFF;
        end else if (ce) begin
            s1_valid_r <= s1_valid_nxt;
            s1_write_r <= s1_write_nxt;
            s1_addr_r  <= s1_addr_nxt;
            s1_lane_r  <= bus.byte_lane_write_n;
            s2_valid_r <= s1_valid_r;
            s2_write_r <= s1_write_r;
            s2_addr_r  <= s1_addr_r;
            s2_lane_r  <= s1_lane_r;
        end
    end

    // Read data stays on the bus through gated clocks.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            q_r       <= '0;
            out_act_r <= 1'h0;
            oe_r      <= 1'h0;
        end else begin
            oe_r <= oe_nxt;
            if (ce) begin
                out_act_r <= read_due;
                q_r       <= rd_word;
            end
        end
    end

    // Storage depth is small; upper address bits alias onto it.
    always_ff @(posedge sys_clk_i) begin
        if (wr_en) begin
            mem_r[wr_idx] <= merge_lanes(mem_r[wr_idx], bus.bus_dq,
                                         s2_lane_r);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            beat_index_o <= sram_bus_pkg::BEAT_FIRST;
            pipe_busy_o  <= 1'h0;
        end else begin
            beat_index_o <= cnt_r;
            pipe_busy_o  <= s1_valid_r || s2_valid_r || burst_act_r;
        end
    end

endmodule
`default_nettype wire

/* File: logic/sram_bus_pkg.sv */
// Shared constants and types for the pipelined burst memory bus.
// Function
// - Write data follows load by two enabled clocks.
// - Advance high steps burst counter, one beat each.
// - Controller holds byte writes low every burst beat; this controller drives each queued entry's lane_n as given.
// - New load allowed on fourth beat clock.
// - Gated clock ignores inputs, pipeline and data hold.
// - Read latency counts enabled clocks only.
// - Stalled writes: data on second enabled clock.
// - Consecutive loads give back-to-back data beats.
// - Deselect starts nothing; pending read still completes.
// - Bus floats two clocks after deselect.
// - Read load during earlier data accepted at once.
// - Write data still driven despite following deselects.
// - Pending write accepted across deselect cycles.
// - Data outputs float after first clock edge.
// - Burst counter wraps after fourth beat.
package sram_bus_pkg;

    localparam int ADDR_W     = 17;
    localparam int LANES      = 4;
    localparam int LANE_W     = 9;
    localparam int DATA_W     = LANES * LANE_W;
    localparam int BEAT_W     = 2;
    localparam int MEM_AW     = 6;
    localparam int MEM_WORDS  = 1 << MEM_AW;
    localparam int FIFO_DEPTH = 4;

    localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
    localparam logic [BEAT_W-1:0] BEAT_STEP  = 2'h1;
    localparam logic [LANES-1:0]  LANES_OFF  = 4'hf;
    localparam logic              GATE_RST   = 1'h0;
    localparam logic              OE_N_RST   = 1'h1;
    localparam logic              SEL_RST    = 1'h0;

    typedef struct packed {
        logic              write;
        logic              cont;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0]  lane_n;
        logic [DATA_W-1:0] data;
    } cmd_t;

endpackage

/* File: logic/sram_bus_if.sv */
// Pin bundle between the memory device and its controller.
`timescale 1ns/1ps
`default_nettype none
interface sram_bus_if;

    logic [sram_bus_pkg::ADDR_W-1:0] addr;
    logic                            read_write;
    logic                            advance_or_load;
    logic                            chip_select_a_n;
    logic                            chip_select_b;
    logic                            chip_select_c_n;
    logic                            clock_gate_n;
    logic [sram_bus_pkg::LANES-1:0]  byte_lane_write_n;
    logic                            output_enable_n;
    logic [sram_bus_pkg::DATA_W-1:0] ctrl_dq;
    logic                            ctrl_dq_oe;
    logic [sram_bus_pkg::DATA_W-1:0] dev_dq;
    logic                            dev_dq_oe;
    logic [sram_bus_pkg::DATA_W-1:0] bus_dq;
    logic                            bus_float;
    logic                            bus_clash;

    // A floating bus reads as zero so neither end ever samples unknowns.
    assign bus_dq    = dev_dq_oe ? dev_dq : (ctrl_dq_oe ? ctrl_dq : '0);
    assign bus_float = !dev_dq_oe && !ctrl_dq_oe;
    assign bus_clash = dev_dq_oe && ctrl_dq_oe;

    modport dev (
        input  addr, read_write, advance_or_load, chip_select_a_n,
        input  chip_select_b, chip_select_c_n, clock_gate_n,
        input  byte_lane_write_n, output_enable_n, bus_dq,
        output dev_dq, dev_dq_oe
    );

    modport ctrl (
        output addr, read_write, advance_or_load, chip_select_a_n,
        output chip_select_b, chip_select_c_n, clock_gate_n,
        output byte_lane_write_n, output_enable_n, ctrl_dq, ctrl_dq_oe,
        input  bus_dq
    );

endinterface
`default_nettype wire

/* File: logic/cmd_fifo.sv */
// Small first-in first-out buffer held in flip-flops.
`timescale 1ns/1ps
`default_nettype none
module cmd_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    input  wire logic         sys_clk_i,
    input  wire logic         reset_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  store_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    logic [CW-1:0] count_nxt;
    logic          push;
    logic          pop;

    assign push       = in_valid_i && in_ready_o;
    assign pop        = out_valid_o && out_ready_i;
    assign count_nxt  = count_r + CW'(push) - CW'(pop);
    assign out_data_o = store_r[rd_ptr_r];

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wr_ptr_r    <= '0;
            rd_ptr_r    <= '0;
            count_r     <= '0;
            in_ready_o  <= 1'h1;
            out_valid_o <= 1'h0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r     <= count_nxt;
            in_ready_o  <= count_nxt != CW'(DEPTH);
            out_valid_o <= count_nxt != '0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            store_r[wr_ptr_r] <= in_data_i;
        end
    end

endmodule
`default_nettype wire

/* File: logic/sram_bus_ctrl.sv */
// Controller end: turns queued bus-cycle entries into memory pin activity.
`timescale 1ns/1ps
`default_nettype none
module sram_bus_ctrl (
    input  wire logic                            sys_clk_i,
    input  wire logic                            reset_i,
    sram_bus_if.ctrl                             bus,
    input  wire logic                            cmd_valid_i,
    output logic                                 cmd_ready_o,
    input  wire logic                            cmd_write_i,
    input  wire logic                            cmd_cont_i,
    input  wire logic [sram_bus_pkg::ADDR_W-1:0] cmd_addr_i,
    input  wire logic [sram_bus_pkg::LANES-1:0]  cmd_lane_n_i,
    input  wire logic [sram_bus_pkg::DATA_W-1:0] cmd_data_i,
    input  wire logic                            stall_i,
    output logic                                 rd_valid_o,
    output logic [sram_bus_pkg::DATA_W-1:0]      rd_data_o
);
    sram_bus_pkg::cmd_t in_cmd;
    sram_bus_pkg::cmd_t head;
    logic               head_valid;
    logic               gate_r;
    logic               pres_valid_r;
    logic               pres_write_r;
    logic [sram_bus_pkg::DATA_W-1:0] pres_data_r;
    logic               sel_r;
    logic               oe_n_r;
    logic               p1_valid_r;
    logic               p1_write_r;
    logic [sram_bus_pkg::DATA_W-1:0] p1_data_r;
    logic               p2_read_r;
    logic               enabled;
    logic               slot;

    assign in_cmd = '{write: cmd_write_i, cont: cmd_cont_i, addr: cmd_addr_i,
                      lane_n: cmd_lane_n_i, data: cmd_data_i};

    // The queue lets the user run ahead while the bus is gated off.
    cmd_fifo #(
        .W     ($bits(sram_bus_pkg::cmd_t)),
        .DEPTH (sram_bus_pkg::FIFO_DEPTH)
    ) cmd_fifo_i (
        .sys_clk_i   (sys_clk_i),
        .reset_i     (reset_i),
        .in_valid_i  (cmd_valid_i),
        .in_ready_o  (cmd_ready_o),
        .in_data_i   (in_cmd),
        .out_valid_o (head_valid),
        .out_ready_i (slot),
        .out_data_o  (head)
    );

    // A presented cycle is consumed only on an enabled clock.
    assign enabled = !gate_r;
    assign slot    = enabled || !pres_valid_r;

    assign bus.clock_gate_n    = gate_r;
    assign bus.chip_select_a_n = !sel_r;
    assign bus.chip_select_b   = sel_r;
    assign bus.chip_select_c_n = !sel_r;
    assign bus.output_enable_n = oe_n_r;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            gate_r                <= sram_bus_pkg::GATE_RST;
            oe_n_r                <= sram_bus_pkg::OE_N_RST;
            pres_valid_r          <= 1'h0;
            sel_r                 <= sram_bus_pkg::SEL_RST;
            bus.advance_or_load   <= 1'h0;
            bus.read_write        <= 1'h1;
            bus.byte_lane_write_n <= sram_bus_pkg::LANES_OFF;
            bus.addr              <= '0;
            pres_write_r          <= 1'h0;
            pres_data_r           <= '0;
        end else begin
            gate_r <= stall_i;
            oe_n_r <= 1'h0;
            if (slot) begin
                pres_valid_r          <= head_valid;
                sel_r                 <= head_valid;
                bus.advance_or_load   <= head_valid && head.cont;
                bus.read_write        <= !(head_valid && head.write);
                bus.byte_lane_write_n <= head_valid ? head.lane_n
                                         : sram_bus_pkg::LANES_OFF;
                bus.addr              <= head.addr;
                pres_write_r          <= head_valid && head.write;
                pres_data_r           <= head.data;
            end
        end
    end

    // Pipeline advances on enabled clocks only, so stalls skip the count.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            p1_valid_r     <= 1'h0;
            p1_write_r     <= 1'h0;
            p1_data_r      <= '0;
            p2_read_r      <= 1'h0;
            bus.ctrl_dq    <= '0;
            bus.ctrl_dq_oe <= 1'h0;
            rd_valid_o     <= 1'h0;
            rd_data_o      <= '0;
        end else begin
            rd_valid_o <= enabled && p2_read_r;
            if (enabled) begin
                p1_valid_r     <= pres_valid_r;
                p1_write_r     <= pres_write_r;
                p1_data_r      <= pres_data_r;
                p2_read_r      <= p1_valid_r && !p1_write_r;
                bus.ctrl_dq    <= p1_data_r;
                bus.ctrl_dq_oe <= p1_valid_r && p1_write_r;
                rd_data_o      <= bus.bus_dq;
            end
        end
    end

endmodule
`default_nettype wire

/* File: test/sram_bus_props.sv */
// Bus-cycle checker watching the pins between controller and device.
`timescale 1ns/1ps
`default_nettype none
module sram_bus_props (
    input wire logic                            sys_clk_i,
    input wire logic                            reset_i,
    input wire logic                            read_write,
    input wire logic                            advance_or_load,
    input wire logic                            chip_select_a_n,
    input wire logic                            chip_select_b,
    input wire logic                            chip_select_c_n,
    input wire logic                            clock_gate_n,
    input wire logic [sram_bus_pkg::LANES-1:0]  byte_lane_write_n,
    input wire logic                            output_enable_n,
    input wire logic                            ctrl_dq_oe,
    input wire logic [sram_bus_pkg::DATA_W-1:0] dev_dq,
    input wire logic                            dev_dq_oe,
    input wire logic                            bus_clash
);
    wire sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
    wire en  = !clock_gate_n;

    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_wr_load;
        en && !advance_or_load && sel && !read_write;
    endsequence
    sequence s_rd_load;
        en && !advance_or_load && sel && read_write && !output_enable_n;
    endsequence
    sequence s_desel;
        en && !advance_or_load && !sel;
    endsequence

    a_write_data:
        assert property (s_wr_load ##1 en ##1 en |-> ctrl_dq_oe)
        else $error("write data missing two enabled clocks after load");
    a_write_stall:
        assert property (s_wr_load ##1 !en ##1 en ##1 !en ##1 !en ##1 en
                         |-> ctrl_dq_oe)
        else $error("stalled write data not on second enabled clock");
    a_read_data:
        assert property (s_rd_load ##1 (en && !output_enable_n) |=> dev_dq_oe)
        else $error("read data not driven two clocks after load");
    a_read_stall:
        assert property (s_rd_load ##1 !en ##1 (en && !output_enable_n)
                         |=> dev_dq_oe)
        else $error("stalled read data not on second enabled clock");
    a_stall_hold:
        assert property (clock_gate_n && !output_enable_n
                         |=> $stable(dev_dq) && $stable(dev_dq_oe))
        else $error("device output moved on a gated clock");
    a_bus_floats:
        assert property (s_desel ##1 s_desel |=> !dev_dq_oe)
        else $error("device still drives after two deselects");
    a_oe_off:
        assert property (output_enable_n |=> !dev_dq_oe)
        else $error("device drives while output enable is off");
    // Reset itself is the cause here, so this one is never disabled.
    a_reset_float:
        assert property (disable iff (1'b0) reset_i |=> !dev_dq_oe)
        else $error("device drives the bus after a reset edge");
    a_burst_lanes:
        assert property (s_wr_load ##1 (en && advance_or_load)
                         |-> byte_lane_write_n == '0)
        else $error("burst write beat without all lanes enabled");
    a_write_lanes:
        assert property (s_wr_load |-> byte_lane_write_n
                                       != sram_bus_pkg::LANES_OFF)
        else $error("write load with every lane disabled");
    a_no_clash:
        assert property (!bus_clash)
        else $error("both ends drive the data bus");
endmodule
`default_nettype wire

/* File: test/pipelined_burst_sram_bus_tb.sv */
// Self-checking bench for controller and device joined by their bus.
`timescale 1ns/1ps
`default_nettype none
module pipelined_burst_sram_bus_tb;
    localparam int LN = sram_bus_pkg::LANES;
    localparam int LW = sram_bus_pkg::LANE_W;
    logic                              sys_clk_i = 1'b0;
    logic                              reset_i = 1'b1;
    logic                              cmd_valid_i = 1'b0;
    logic                              cmd_ready_o;
    logic                              cmd_write_i = 1'b0;
    logic                              cmd_cont_i = 1'b0;
    logic [sram_bus_pkg::ADDR_W-1:0]   cmd_addr_i = '0;
    logic [LN-1:0]                     cmd_lane_n_i = 4'hf;
    logic [sram_bus_pkg::DATA_W-1:0]   cmd_data_i = '0;
    logic                              stall_i = 1'b0;
    logic                              order_i = 1'b0;
    logic                              rd_valid_o;
    logic [sram_bus_pkg::DATA_W-1:0]   rd_data_o;
    logic [sram_bus_pkg::BEAT_W-1:0]   beat_index_o;
    logic                              pipe_busy_o;
    logic [sram_bus_pkg::DATA_W-1:0]   mem_m [sram_bus_pkg::MEM_WORDS];
    logic [sram_bus_pkg::DATA_W-1:0]   exp_q [$];
    logic [sram_bus_pkg::DATA_W-1:0]   got_q [$];
    logic [1:0]                        beat = 2'h0;
    int                                base = 0;
    int                                n_fail = 0;
    int                                tests_run = 0;
    int                                cyc = 0;
    int                                refused;
    bit                                acc;

    always #25 sys_clk_i = ~sys_clk_i;

    sram_bus_if sram_bus_if_i ();
    sram_bus_ctrl sram_bus_ctrl_i (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .bus(sram_bus_if_i),
        .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
        .cmd_write_i(cmd_write_i), .cmd_cont_i(cmd_cont_i),
        .cmd_addr_i(cmd_addr_i), .cmd_lane_n_i(cmd_lane_n_i),
        .cmd_data_i(cmd_data_i), .stall_i(stall_i),
        .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o)
    );
    sram_bus_mem sram_bus_mem_i (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .bus(sram_bus_if_i),
        .burst_order_select_i(order_i), .beat_index_o(beat_index_o),
        .pipe_busy_o(pipe_busy_o)
    );
    sram_bus_props sram_bus_props_i (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .read_write(sram_bus_if_i.read_write),
        .advance_or_load(sram_bus_if_i.advance_or_load),
        .chip_select_a_n(sram_bus_if_i.chip_select_a_n),
        .chip_select_b(sram_bus_if_i.chip_select_b),
        .chip_select_c_n(sram_bus_if_i.chip_select_c_n),
        .clock_gate_n(sram_bus_if_i.clock_gate_n),
        .byte_lane_write_n(sram_bus_if_i.byte_lane_write_n),
        .output_enable_n(sram_bus_if_i.output_enable_n),
        .ctrl_dq_oe(sram_bus_if_i.ctrl_dq_oe),
        .dev_dq(sram_bus_if_i.dev_dq), .dev_dq_oe(sram_bus_if_i.dev_dq_oe),
        .bus_clash(sram_bus_if_i.bus_clash)
    );

    function automatic logic [35:0] pat(input int i);
        return {4'ha, 16'h5a5a, i[15:0]};
    endfunction

    task automatic check(input string what, input logic [35:0] seen,
                         input logic [35:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One bus entry offered for one cycle; the model moves only if taken.
    task automatic offer(input logic w, input logic c, input int a,
                         input logic [3:0] l, input int i, output bit ok);
        logic [5:0] idx;
        ok = (cmd_ready_o === 1'b1);
        cmd_valid_i  = 1'b1;
        cmd_write_i  = w;
        cmd_cont_i   = c;
        cmd_addr_i   = 17'(a);
        cmd_lane_n_i = l;
        cmd_data_i   = pat(i);
        if (ok) begin
            if (!c) begin
                base = a;
                beat = 2'h0;
            end else begin
                beat = beat + 2'h1;
            end
            idx = {base[5:2], order_i ? base[1:0] ^ beat : base[1:0] + beat};
            for (int j = 0; j < LN; j++) begin
                if (w && !l[j])
                    mem_m[idx][LW*j +: LW] = cmd_data_i[LW*j +: LW];
            end
            if (!w) exp_q.push_back(mem_m[idx]);
        end
        @(negedge sys_clk_i);
    endtask

    task automatic put(input logic w, input logic c, input int a,
                       input logic [3:0] l, input int i);
        bit ok;
        ok = 1'b0;
        while (!ok) offer(w, c, a, l, i, ok);
    endtask

    task automatic gap(input int n);
        cmd_valid_i = 1'b0;
        repeat (n) @(negedge sys_clk_i);
    endtask

    task automatic settle(input string name);
        int k;
        k = 0;
        gap(1);
        stall_i = 1'b0;
        while (got_q.size() < exp_q.size() && k < 300) begin
            @(negedge sys_clk_i);
            k++;
        end
        // A few spare cycles so that a stray extra read shows up too.
        repeat (8) @(negedge sys_clk_i);
        check("read count", 36'(got_q.size()), 36'(exp_q.size()));
        while (got_q.size() > 0 && exp_q.size() > 0)
            check(name, got_q.pop_front(), exp_q.pop_front());
        got_q.delete();
        exp_q.delete();
        check("idle float", sram_bus_if_i.bus_float, 1'b1);
        check("idle busy", pipe_busy_o, 1'b0);
        $display("test %s done", name);
    endtask

    always @(negedge sys_clk_i) begin
        if (rd_valid_o === 1'b1) got_q.push_back(rd_data_o);
    end

    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            tally_and_finish;
        end
    end

    initial begin
        repeat (5) @(negedge sys_clk_i);
        reset_i = 1'b0;
        @(negedge sys_clk_i);
        check("reset float", sram_bus_if_i.dev_dq_oe, 1'b0);
        check("reset ready", cmd_ready_o, 1'b1);
        put(1, 0, 5, 4'h0, 1);
        put(1, 0, 5, 4'ha, 2);
        put(0, 0, 5, 4'hf, 0);
        settle("single");
        for (int i = 0; i < 4; i++) put(1, i > 0, 8, 4'h0, 10 + i);
        for (int i = 0; i < 5; i++) put(1, i > 0, 12, 4'h0, 20 + i);
        for (int i = 0; i < 4; i++) put(0, i > 0, 8, 4'hf, 0);
        for (int i = 0; i < 5; i++) put(0, i > 0, 12, 4'hf, 0);
        settle("burst linear");
        order_i = 1'b1;
        for (int i = 0; i < 4; i++) put(1, i > 0, 17, 4'h0, 30 + i);
        gap(6);
        check("beat index", beat_index_o, 2'h3);
        for (int i = 0; i < 4; i++) put(0, 1'b0, 16 + i, 4'hf, 0);
        settle("burst interleaved");
        for (int i = 0; i < 3; i++) begin
            put(1, 1'b0, 20 + i, 4'h0, 40 + i);
            gap(i + 1);
        end
        for (int i = 0; i < 3; i++) begin
            put(0, 1'b0, 20 + i, 4'hf, 0);
            gap(i + 1);
        end
        settle("deselect");
        for (int i = 0; i < 6; i++) begin
            stall_i = i[0];
            put(1, 1'b0, 24 + i, 4'h0, 50 + i);
        end
        for (int i = 0; i < 6; i++) begin
            stall_i = !i[0];
            put(0, 1'b0, 24 + i, 4'hf, 0);
        end
        settle("stall toggle");
        // With the device gated the queue drains at most one entry, so it must refuse.
        stall_i = 1'b1;
        refused = 0;
        for (int i = 0; i < 7; i++) begin
            offer(0, 1'b0, 8 + i, 4'hf, 0, acc);
            if (!acc) refused++;
        end
        check("full refuses", 36'(refused > 0), 36'h0_0000_0001);
        settle("fill and drain");
        tally_and_finish;
    end
endmodule
`default_nettype wire
